// File: verilog/pmr_pkg.sv
// package of the monitor result and alert flag register bank
// assumes one clock domain for the bank; the link clock is sampled, not used as a clock
package pmr_pkg;

  // register offsets as seen by the serial register engine
  localparam logic [7:0] OFS_BUS    = 8'h05;
  localparam logic [7:0] OFS_TEMP   = 8'h06;
  localparam logic [7:0] OFS_CURR   = 8'h07;
  localparam logic [7:0] OFS_POWER  = 8'h08;
  localparam logic [7:0] OFS_ENERGY = 8'h09;
  localparam logic [7:0] OFS_CHARGE = 8'h0A;
  localparam logic [7:0] OFS_DIAG   = 8'h0B;

  // widths
  localparam int ADDR_W  = 8;
  localparam int BUS_W   = 20;
  localparam int TEMP_W  = 16;
  localparam int CURR_W  = 20;
  localparam int POWER_W = 24;
  localparam int ACC_W   = 40;
  localparam int DIAG_W  = 16;
  localparam int LIM_W   = 16;
  localparam int BLIM_W  = 15;
  localparam int RD_W    = 40;
  localparam int PAD_W   = 4;
  localparam int AVG_W   = 3;

  // diagnostic register fields
  localparam int B_HOLD   = 15;
  localparam int B_CNVEN  = 14;
  localparam int B_AVGSEL = 13;
  localparam int B_POL    = 12;
  localparam int B_EOVF   = 11;
  localparam int B_COVF   = 10;
  localparam int B_MOVF   = 9;
  localparam int B_RSV    = 8;
  localparam int B_LIM_LO = 2;
  localparam int B_CONV   = 1;
  localparam int B_TRIM   = 0;
  localparam int N_LIM    = 6;

  // limit flag index, bit = B_LIM_LO + index
  localparam int LIM_POWER = 0;
  localparam int LIM_BUSUV = 1;
  localparam int LIM_BUSOV = 2;
  localparam int LIM_UNDC  = 3;
  localparam int LIM_OVRC  = 4;
  localparam int LIM_TEMP  = 5;

  // reset values
  localparam logic [DIAG_W-1:0] DIAG_RESET = 16'h0001;
  localparam logic [AVG_W-1:0]  AVG_NONE   = 3'h0;

  // result bits that line up with a limit register lsb
  localparam int CURR_CMP_LSB  = 4;
  localparam int BUS_CMP_LSB   = 4;
  localparam int POWER_CMP_LSB = 8;

endpackage

// File: verilog/pmr_cmp_if.sv
// interface carrying results and limits to the limit comparator and conditions back
// assumes all members are driven in the bank's clock domain
interface pmr_cmp_if;
  logic signed [pmr_pkg::TEMP_W-1:0] temp;
  logic signed [pmr_pkg::LIM_W-1:0]  curr;
  logic        [pmr_pkg::LIM_W-1:0]  bus;
  logic        [pmr_pkg::LIM_W-1:0]  power;
  logic signed [pmr_pkg::LIM_W-1:0]  temp_lim;
  logic signed [pmr_pkg::LIM_W-1:0]  over_curr_lim;
  logic signed [pmr_pkg::LIM_W-1:0]  under_curr_lim;
  logic        [pmr_pkg::LIM_W-1:0]  bus_over_lim;
  logic        [pmr_pkg::LIM_W-1:0]  bus_under_lim;
  logic        [pmr_pkg::LIM_W-1:0]  power_lim;
  logic        [pmr_pkg::N_LIM-1:0]  cond;

  modport bank (output temp, curr, bus, power, temp_lim, over_curr_lim, under_curr_lim,
                output bus_over_lim, bus_under_lim, power_lim, input cond);
  modport cmp  (input temp, curr, bus, power, temp_lim, over_curr_lim, under_curr_lim,
                input bus_over_lim, bus_under_lim, power_lim, output cond);
endinterface

// File: verilog/pmr_limit_cmp.sv
// limit comparator: one condition per limit flag, purely combinational
// assumes results were already scaled to the limit registers' lsb
module pmr_limit_cmp (
  pmr_cmp_if.cmp c
);
  always_comb begin
    c.cond                     = '0;
    c.cond[pmr_pkg::LIM_TEMP]  = c.temp > c.temp_lim;
    c.cond[pmr_pkg::LIM_OVRC]  = c.curr > c.over_curr_lim;
    c.cond[pmr_pkg::LIM_UNDC]  = c.curr < c.under_curr_lim;
    c.cond[pmr_pkg::LIM_BUSOV] = c.bus > c.bus_over_lim;
    c.cond[pmr_pkg::LIM_BUSUV] = c.bus < c.bus_under_lim;
    c.cond[pmr_pkg::LIM_POWER] = c.power > c.power_lim;
  end
endmodule

// File: verilog/pmr_link_edge.sv
// two-flop synchroniser for the serial link clock with a falling edge pulse
// assumes the link clock is far slower than clk_i
module pmr_link_edge (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic link_clk_i,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (ce_i) begin
      meta <= link_clk_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign fall_o = prev & ~sync;
endmodule

// File: verilog/pmr_bank.sv
// result registers and diagnostic / alert flags of the power monitor
// assumes converter, accumulator and limit inputs are on clk_i; the serial
// engine presents one-cycle read and write strobes on clk_i
//
// Behaviour
// - bus voltage: 20-bit field at 23:4, never negative, low nibble zero
// - die temperature: 16-bit two's complement at 15:0
// - current: signed 20-bit field at 23:4, low nibble zero
// - power: 24-bit unsigned at 23:0
// - energy: 40-bit unsigned at 39:0
// - charge: 40-bit two's complement at 39:0
// - hold mode off: pin and flags return idle once the fault is gone
// - hold mode on: pin and flags stay active until the flags register is read
// - conversion-ready enable routes the conversion-done flag to the pin
// - compare select: raw samples or only completed averages
// - polarity bit: 0 active-low open-drain, 1 active-high open-drain
// - energy overflow flag sticks until an accumulator clear
// - charge overflow flag sticks until an accumulator clear
// - arithmetic overflow flag clears on triggered conversion or accumulator clear
// - over-temperature flag; read clears it in hold mode
// - over- and under-current flags; read clears them in hold mode
// - bus over- and under-voltage flags; read clears them in hold mode
// - power over-limit flag; read clears it in hold mode
// - conversion-done flag; triggered start clears it in either mode, read clears it in hold mode
// - checksum status resets to one, drops on trim checksum error
// - bit 8 of the flags register always reads zero
// - with averaging, result registers load only when averaging completes
// - temperature limit compares directly against die temperature
module pmr_bank (
  // clock, reset, enable
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          ce_i,
  // register access from the serial engine
  input  wire logic [pmr_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic                          reg_wr_i,
  input  wire logic [pmr_pkg::DIAG_W-1:0]    reg_wdata_i,
  output logic      [pmr_pkg::RD_W-1:0]      reg_rdata_o,
  output logic                               reg_rvalid_o,
  // serial link clock pin
  input  wire logic                          link_clk_i,
  // converter results
  input  wire logic                          sample_valid_i,
  input  wire logic                          avg_done_i,
  input  wire logic [pmr_pkg::AVG_W-1:0]     averaging_count_i,
  input  wire logic [pmr_pkg::BUS_W-1:0]     result_bus_i,
  input  wire logic [pmr_pkg::TEMP_W-1:0]    result_temp_i,
  input  wire logic [pmr_pkg::CURR_W-1:0]    result_curr_i,
  input  wire logic [pmr_pkg::POWER_W-1:0]   result_power_i,
  // accumulators and health events
  input  wire logic                          accum_update_i,
  input  wire logic [pmr_pkg::ACC_W-1:0]     energy_i,
  input  wire logic [pmr_pkg::ACC_W-1:0]     charge_i,
  input  wire logic                          energy_wrap_i,
  input  wire logic                          charge_wrap_i,
  input  wire logic                          math_ovf_i,
  input  wire logic                          accumulator_clear_i,
  input  wire logic                          trig_conv_start_i,
  input  wire logic                          checksum_err_i,
  // limit thresholds
  input  wire logic [pmr_pkg::LIM_W-1:0]     temp_lim_i,
  input  wire logic [pmr_pkg::LIM_W-1:0]     over_curr_lim_i,
  input  wire logic [pmr_pkg::LIM_W-1:0]     under_curr_lim_i,
  input  wire logic [pmr_pkg::BLIM_W-1:0]    bus_over_lim_i,
  input  wire logic [pmr_pkg::BLIM_W-1:0]    bus_under_lim_i,
  input  wire logic [pmr_pkg::LIM_W-1:0]     power_lim_i,
  // open-drain alert pin
  output logic                               alert_pin_o,
  output logic                               alert_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // result registers
  logic [pmr_pkg::BUS_W-1:0]   bus_voltage_result;
  logic [pmr_pkg::TEMP_W-1:0]  die_heat_result;
  logic [pmr_pkg::CURR_W-1:0]  current_result;
  logic [pmr_pkg::POWER_W-1:0] power_result;
  logic [pmr_pkg::ACC_W-1:0]   energy_accumulator;
  logic [pmr_pkg::ACC_W-1:0]   charge_accumulator;
  logic                        load_evt;

  // without averaging every sample is final
  assign load_evt = avg_done_i | (sample_valid_i & (averaging_count_i == pmr_pkg::AVG_NONE));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_voltage_result <= '0;
      die_heat_result    <= '0;
      current_result     <= '0;
      power_result       <= '0;
    end else if (ce_i && load_evt) begin
      bus_voltage_result <= result_bus_i;
      die_heat_result    <= result_temp_i;
      current_result     <= result_curr_i;
      power_result       <= result_power_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      energy_accumulator <= '0;
      charge_accumulator <= '0;
    end else if (ce_i && accumulator_clear_i) begin
      energy_accumulator <= '0;
      charge_accumulator <= '0;
    end else if (ce_i && accum_update_i) begin
      energy_accumulator <= energy_i;
      charge_accumulator <= charge_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit comparison
  pmr_cmp_if cmp_bus ();
  logic cmp_evt;

  assign cmp_bus.temp           = result_temp_i;
  assign cmp_bus.curr           = result_curr_i[pmr_pkg::CURR_CMP_LSB +: pmr_pkg::LIM_W];
  assign cmp_bus.bus            = result_bus_i[pmr_pkg::BUS_CMP_LSB +: pmr_pkg::LIM_W];
  assign cmp_bus.power          = result_power_i[pmr_pkg::POWER_CMP_LSB +: pmr_pkg::LIM_W];
  assign cmp_bus.temp_lim       = temp_lim_i;
  assign cmp_bus.over_curr_lim  = over_curr_lim_i;
  assign cmp_bus.under_curr_lim = under_curr_lim_i;
  assign cmp_bus.bus_over_lim   = {1'b0, bus_over_lim_i};
  assign cmp_bus.bus_under_lim  = {1'b0, bus_under_lim_i};
  assign cmp_bus.power_lim      = power_lim_i;

  pmr_limit_cmp u_cmp (
    .c (cmp_bus.cmp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control bits, host writable
  logic alert_hold_mode;
  logic conv_ready_alert_en;
  logic averaged_compare_sel;
  logic alert_polarity;
  logic wr_diag;
  logic rd_diag;

  assign wr_diag = reg_wr_i & (reg_addr_i == pmr_pkg::OFS_DIAG);
  assign rd_diag = reg_rd_i & (reg_addr_i == pmr_pkg::OFS_DIAG);
  assign cmp_evt = averaged_compare_sel ? load_evt : sample_valid_i;

  // only the four control bits take write data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alert_hold_mode      <= pmr_pkg::DIAG_RESET[pmr_pkg::B_HOLD];
      conv_ready_alert_en  <= pmr_pkg::DIAG_RESET[pmr_pkg::B_CNVEN];
      averaged_compare_sel <= pmr_pkg::DIAG_RESET[pmr_pkg::B_AVGSEL];
      alert_polarity       <= pmr_pkg::DIAG_RESET[pmr_pkg::B_POL];
    end else if (ce_i && wr_diag) begin
      alert_hold_mode      <= reg_wdata_i[pmr_pkg::B_HOLD];
      conv_ready_alert_en  <= reg_wdata_i[pmr_pkg::B_CNVEN];
      averaged_compare_sel <= reg_wdata_i[pmr_pkg::B_AVGSEL];
      alert_polarity       <= reg_wdata_i[pmr_pkg::B_POL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // deferred read-clear, fired by the link clock falling edge after capture
  logic                      link_fall;
  logic                      clr_pend;
  logic                      clr_fire;
  logic [pmr_pkg::N_LIM-1:0] clr_lim_mask;
  logic                      clr_conv_mask;
  logic [pmr_pkg::N_LIM-1:0] limit_flag;
  logic                      conv_done_flag;

  pmr_link_edge u_link (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .link_clk_i (link_clk_i),
    .fall_o     (link_fall)
  );

  assign clr_fire = clr_pend & link_fall & ~rd_diag;

  // masks hold only what the host saw, so later events survive the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clr_pend      <= 1'b0;
      clr_lim_mask  <= '0;
      clr_conv_mask <= 1'b0;
    end else if (ce_i) begin
      if (rd_diag) begin
        clr_pend      <= 1'b1;
        clr_lim_mask  <= clr_pend ? (clr_lim_mask | limit_flag) : limit_flag;
        clr_conv_mask <= conv_done_flag | (clr_pend & clr_conv_mask);
      end else if (clr_fire) begin
        clr_pend      <= 1'b0;
        clr_lim_mask  <= '0;
        clr_conv_mask <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit flags: transparent follows each compare, hold mode is sticky
  genvar gi;
  generate
    for (gi = 0; gi < pmr_pkg::N_LIM; gi = gi + 1) begin : g_lim
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          limit_flag[gi] <= 1'b0;
        end else if (ce_i) begin
          if (!alert_hold_mode) begin
            if (cmp_evt) begin
              limit_flag[gi] <= cmp_bus.cond[gi];
            end
          end else if (cmp_evt && cmp_bus.cond[gi]) begin
            limit_flag[gi] <= 1'b1;
          end else if (clr_fire && clr_lim_mask[gi]) begin
            limit_flag[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // conversion done: a new completion wins over any clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      conv_done_flag <= pmr_pkg::DIAG_RESET[pmr_pkg::B_CONV];
    end else if (ce_i) begin
      if (load_evt) begin
        conv_done_flag <= 1'b1;
      end else if (trig_conv_start_i) begin
        conv_done_flag <= 1'b0;
      end else if (alert_hold_mode && clr_fire && clr_conv_mask) begin
        conv_done_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // health flags
  logic energy_overflow_flag;
  logic charge_overflow_flag;
  logic arith_overflow_flag;
  logic trim_checksum_ok;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      energy_overflow_flag <= pmr_pkg::DIAG_RESET[pmr_pkg::B_EOVF];
      charge_overflow_flag <= pmr_pkg::DIAG_RESET[pmr_pkg::B_COVF];
    end else if (ce_i) begin
      if (energy_wrap_i) begin
        energy_overflow_flag <= 1'b1;
      end else if (accumulator_clear_i) begin
        energy_overflow_flag <= 1'b0;
      end
      if (charge_wrap_i) begin
        charge_overflow_flag <= 1'b1;
      end else if (accumulator_clear_i) begin
        charge_overflow_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arith_overflow_flag <= pmr_pkg::DIAG_RESET[pmr_pkg::B_MOVF];
    end else if (ce_i) begin
      if (math_ovf_i) begin
        arith_overflow_flag <= 1'b1;
      end else if (trig_conv_start_i || accumulator_clear_i) begin
        arith_overflow_flag <= 1'b0;
      end
    end
  end

  // a checksum error is permanent until reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      trim_checksum_ok <= pmr_pkg::DIAG_RESET[pmr_pkg::B_TRIM];
    end else if (ce_i && checksum_err_i) begin
      trim_checksum_ok <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [pmr_pkg::DIAG_W-1:0] diag_view;
  logic [pmr_pkg::RD_W-1:0]   next_rdata;

  always_comb begin
    diag_view                                  = '0;
    diag_view[pmr_pkg::B_HOLD]                 = alert_hold_mode;
    diag_view[pmr_pkg::B_CNVEN]                = conv_ready_alert_en;
    diag_view[pmr_pkg::B_AVGSEL]               = averaged_compare_sel;
    diag_view[pmr_pkg::B_POL]                  = alert_polarity;
    diag_view[pmr_pkg::B_EOVF]                 = energy_overflow_flag;
    diag_view[pmr_pkg::B_COVF]                 = charge_overflow_flag;
    diag_view[pmr_pkg::B_MOVF]                 = arith_overflow_flag;
    diag_view[pmr_pkg::B_LIM_LO +: pmr_pkg::N_LIM] = limit_flag;
    diag_view[pmr_pkg::B_CONV]                 = conv_done_flag;
    diag_view[pmr_pkg::B_TRIM]                 = trim_checksum_ok;
  end

  always_comb begin
    next_rdata = '0;
    case (reg_addr_i)
      pmr_pkg::OFS_BUS:    next_rdata[pmr_pkg::PAD_W +: pmr_pkg::BUS_W]  = bus_voltage_result;
      pmr_pkg::OFS_TEMP:   next_rdata[pmr_pkg::TEMP_W-1:0]               = die_heat_result;
      pmr_pkg::OFS_CURR:   next_rdata[pmr_pkg::PAD_W +: pmr_pkg::CURR_W] = current_result;
      pmr_pkg::OFS_POWER:  next_rdata[pmr_pkg::POWER_W-1:0]              = power_result;
      pmr_pkg::OFS_ENERGY: next_rdata                                    = energy_accumulator;
      pmr_pkg::OFS_CHARGE: next_rdata                                    = charge_accumulator;
      pmr_pkg::OFS_DIAG:   next_rdata[pmr_pkg::DIAG_W-1:0]               = diag_view;
      default:             next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert pin: open drain, only ever pulls low
  logic alert_active;

  assign alert_active = (|limit_flag) | (conv_ready_alert_en & conv_done_flag);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alert_pin_o    <= 1'b0;
      alert_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      alert_pin_o    <= 1'b0;
      alert_pin_oe_o <= alert_polarity ? ~alert_active : alert_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_read_flags;
    ce_i && rd_diag;
  endsequence

  chk_bus_load: assert property (ce_i && load_evt |=>
      bus_voltage_result == $past(result_bus_i))
    else $error("bus voltage result did not load");
  chk_avg_wait: assert property (ce_i && sample_valid_i && !avg_done_i
      && averaging_count_i != pmr_pkg::AVG_NONE |=> $stable(current_result))
    else $error("result loaded before averaging finished");
  chk_hold_sticky: assert property (ce_i && alert_hold_mode && limit_flag[pmr_pkg::LIM_TEMP]
      && !clr_fire && !wr_diag |=> limit_flag[pmr_pkg::LIM_TEMP])
    else $error("held flag dropped without read clear");
  chk_transp_drop: assert property (ce_i && !alert_hold_mode && cmp_evt
      && !cmp_bus.cond[pmr_pkg::LIM_OVRC] |=> !limit_flag[pmr_pkg::LIM_OVRC])
    else $error("transparent flag stayed after fault left");
  chk_pin_conv: assert property (ce_i && conv_ready_alert_en && conv_done_flag
      && !alert_polarity |=> alert_pin_oe_o && !alert_pin_o)
    else $error("conversion ready not on pin");
  chk_energy_stick: assert property (ce_i && energy_overflow_flag
      && !accumulator_clear_i |=> energy_overflow_flag)
    else $error("energy overflow cleared without accumulator clear");
  chk_clear_late: assert property (s_read_flags ##1 (!link_fall && ce_i)
      |-> clr_pend)
    else $error("read clear not held for link edge");
  chk_bit8_zero: assert property (s_read_flags |=> !reg_rdata_o[pmr_pkg::B_RSV]
      && reg_rvalid_o)
    else $error("reserved flag bit read as one");
  chk_trim_bad: assert property (ce_i && checksum_err_i |=> !trim_checksum_ok [*2])
    else $error("checksum status not cleared");

endmodule

// File: testbench/pmr_host.sv
// host-side model: drives the serial link clock, in frames only
// assumes the bus pull-up holds the link clock high between frames
module pmr_host (
  // frame request from the bench
  input  wire logic frame_i,
  // serial link clock
  output logic      link_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////
  // odd start offset keeps the link phase unrelated to clk_i
  initial begin
    link_clk_o = 1'b1;
    forever begin
      wait (frame_i === 1'b1);
      #7;
      while (frame_i === 1'b1) begin
        #80 link_clk_o = 1'b0;
        #80 link_clk_o = 1'b1;
      end
    end
  end
endmodule

// File: testbench/tb.sv
// self-checking bench of the result and flag bank
// assumes pmr_host supplies the link clock; reads are checked by a queue
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sv = 1'b0, ad = 1'b0, au = 1'b0;
  logic        ew = 1'b0, cw = 1'b0, mo = 1'b0, ac = 1'b0, ts = 1'b0, ck = 1'b0, frame = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wd = 16'h0000, tl, ocl, ucl, pl, rt;
  logic [14:0] bol, bul;
  logic [2:0]  averaging_count = 3'h0;
  logic [19:0] rb, rc;
  logic [23:0] rp;
  logic [39:0] en, ch, rdata, q[$];
  logic        link, rv, oe, pin_d;
  int          err_total = 0, checks_done = 0, seed = 63941;
  pmr_bank u_pmr_bank (.clk_i(clk_i), .sys_rst_i(rst), .ce_i(1'b1), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .link_clk_i(link),
    .sample_valid_i(sv), .avg_done_i(ad), .averaging_count_i(averaging_count), .result_bus_i(rb), .result_temp_i(rt),
    .result_curr_i(rc), .result_power_i(rp), .accum_update_i(au), .energy_i(en), .charge_i(ch),
    .energy_wrap_i(ew), .charge_wrap_i(cw), .math_ovf_i(mo), .accumulator_clear_i(ac),
    .trig_conv_start_i(ts), .checksum_err_i(ck), .temp_lim_i(tl), .over_curr_lim_i(ocl),
    .under_curr_lim_i(ucl), .bus_over_lim_i(bol), .bus_under_lim_i(bul), .power_lim_i(pl),
    .alert_pin_o(pin_d), .alert_pin_oe_o(oe));
  pmr_host u_pmr_host (.frame_i(frame), .link_clk_o(link));
  ////////////////////////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic chk(logic [39:0] g, logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdx(logic [7:0] a, logic [39:0] e);
    addr = a;
    q.push_back(e);
    pulse(rd);
  endtask
  task automatic wrx(logic [15:0] d);
    addr = 8'h0B;
    wd = d;
    pulse(wr);
  endtask
  task automatic smp(logic [19:0] b, logic [15:0] t, logic [19:0] c, logic [23:0] p, ref logic s);
    rb = b;
    rt = t;
    rc = c;
    rp = p;
    pulse(s);
  endtask
  task automatic lims(logic [15:0] t, logic [15:0] o, logic [15:0] u, logic [15:0] p, logic [14:0] bo,
                      logic [14:0] bu);
    {tl, ocl, ucl, pl, bol, bul} = {t, o, u, p, bo, bu};
  endtask
  // oe lags the flags by one cycle, so settle before looking
  task automatic pin(logic e);
    cyc(3);
    chk(40'(oe), 40'(e));
    chk(40'(pin_d), 40'h0);
  endtask
  task automatic frm;
    frame = 1'b1;
    cyc(30);
    frame = 1'b0;
  endtask
  // an answer that never came leaves its note behind
  task automatic close_out;
    if (q.size() > 0) begin
      err_total++;
    end
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // an empty queue yields unknown, so a stray answer always mismatches
  always @(posedge clk_i) begin
    if (rv === 1'b1) begin
      chk(rdata, (q.size() > 0) ? q.pop_front() : 40'hX);
    end
  end
  initial begin
    #60000;
    err_total++;
    close_out;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [19:0] b, c;
    logic [15:0] t;
    logic [23:0] p;
    lims(16'h7FFF, 16'h7FFF, 16'h8000, 16'hFFFF, 15'h7FFF, 15'h0000);
    {rb, rt, rc, rp, en, ch} = '0;
    cyc(2);
    rst = 1'b0;
    rdx(8'h0B, 40'h0001);
    rdx(8'h05, 40'h0);
    rdx(8'h00, 40'h0);
    repeat (4) begin
      b = 20'($random(seed)) & 20'h7FFFF;
      t = 16'($random(seed));
      c = 20'($random(seed));
      p = 24'($random(seed));
      smp(b, t, c, p, sv);
      rdx(8'h05, {16'h0, b, 4'h0});
      rdx(8'h06, {24'h0, t});
      rdx(8'h07, {16'h0, c, 4'h0});
      rdx(8'h08, {16'h0, p});
      en = 40'({$random(seed), $random(seed)});
      ch = 40'({$random(seed), $random(seed)});
      pulse(au);
      rdx(8'h09, en);
      rdx(8'h0A, ch);
    end
    averaging_count = 3'h2;
    smp(20'h00010, 16'h0, 20'h0, 24'h0, sv);
    rdx(8'h05, {16'h0, b, 4'h0});
    smp(20'h00010, 16'h0, 20'h0, 24'h0, ad);
    rdx(8'h05, 40'h100);
    averaging_count = 3'h0;
    pulse(ew);
    pulse(cw);
    pulse(mo);
    wrx(16'h0FFF);
    rdx(8'h0B, 40'h0E03);
    pulse(ts);
    rdx(8'h0B, 40'h0C01);
    pulse(ac);
    rdx(8'h0B, 40'h0001);
    lims(16'h0000, 16'h0000, 16'h0000, 16'h0010, 15'h0100, 15'h0100);
    smp(20'h02000, 16'h0100, 20'h01000, 24'h002000, sv);
    rdx(8'h0B, 40'h00D7);
    pin(1'b1);
    smp(20'h00100, 16'h0000, 20'hFF000, 24'h0, sv);
    rdx(8'h0B, 40'h002B);
    wrx(16'h8000);
    smp(20'h02000, 16'h0100, 20'h01000, 24'h002000, sv);
    smp(20'h00100, 16'h0000, 20'hFF000, 24'h0, sv);
    rdx(8'h0B, 40'h80FF);
    rdx(8'h0B, 40'h80FF);
    pin(1'b1);
    frm;
    rdx(8'h0B, 40'h8001);
    pin(1'b0);
    // flags raised after the last read must survive the next link edge
    smp(20'h02000, 16'h0100, 20'h01000, 24'h002000, sv);
    frm;
    rdx(8'h0B, 40'h80D7);
    frm;
    wrx(16'h2000);
    averaging_count = 3'h1;
    smp(20'h02000, 16'h0100, 20'h01000, 24'h002000, sv);
    rdx(8'h0B, 40'h2001);
    smp(20'h02000, 16'h0100, 20'h01000, 24'h002000, ad);
    rdx(8'h0B, 40'h20D7);
    averaging_count = 3'h0;
    lims(16'h7FFF, 16'h7FFF, 16'h8000, 16'hFFFF, 15'h7FFF, 15'h0000);
    wrx(16'h4000);
    smp(20'h0, 16'h0, 20'h0, 24'h0, sv);
    pin(1'b1);
    pulse(ts);
    pin(1'b0);
    // completion pending while routing is off must stay off the pin
    smp(20'h0, 16'h0, 20'h0, 24'h0, sv);
    wrx(16'h1000);
    pin(1'b1);
    pulse(ck);
    rdx(8'h0B, 40'h1002);
    pulse(rst);
    pin(1'b0);
    rdx(8'h0B, 40'h0001);
    rdx(8'h05, 40'h0);
    cyc(4);
    close_out;
  end
endmodule
